// ---- rtl/lcr_pkg.sv ----
// register map, field positions, reset values and encodings for the lcd
// configuration register bank; assumes a single 20 MHz bus clock domain
package lcr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [16:0] OFS_ID      = 17'h00000;
  localparam logic [16:0] OFS_BUFSZ   = 17'h00001;
  localparam logic [16:0] OFS_STRAP   = 17'h00002;
  localparam logic [16:0] OFS_MCLK    = 17'h00004;
  localparam logic [16:0] OFS_PCLK    = 17'h00005;
  localparam logic [16:0] OFS_WDATA_B = 17'h00008;
  localparam logic [16:0] OFS_WDATA_G = 17'h00009;
  localparam logic [16:0] OFS_WDATA_R = 17'h0000a;
  localparam logic [16:0] OFS_WPTR    = 17'h0000b;
  localparam logic [16:0] OFS_RDATA_B = 17'h0000c;
  localparam logic [16:0] OFS_RDATA_G = 17'h0000d;
  localparam logic [16:0] OFS_RDATA_R = 17'h0000e;
  localparam logic [16:0] OFS_RPTR    = 17'h0000f;
  localparam logic [16:0] OFS_PANEL   = 17'h00010;

  // ---------------------------------------------------------------
  // field positions and values
  // ---------------------------------------------------------------
  localparam int          MCLK_DIV_LSB  = 4;
  localparam int          PCLK_DIV_LSB  = 4;
  localparam int          PCLK_SRC_LSB  = 0;
  localparam int          LUT_DATA_LSB  = 2;
  localparam int          PANEL_WID_LSB = 4;
  localparam int          PANEL_RES_BIT = 3;
  localparam int          PANEL_MON_BIT = 6;
  localparam int          PANEL_FMT_BIT = 7;
  localparam int          PANEL_KND_LSB = 0;
  localparam logic [7:0]  RST_VAL       = 8'h00;
  localparam logic [7:0]  BUF_SIZE_VAL  = 8'h14;
  localparam logic [2:0]  PCLK_DIV8_CNT = 3'h7;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LCR_SRC_MEM = 2'b00,
    LCR_SRC_BUS = 2'b01,
    LCR_SRC_PRI = 2'b10,
    LCR_SRC_SEC = 2'b11
  } lcr_pix_src_t;

  typedef enum logic [1:0] {
    LCR_PNL_PASSIVE = 2'b00,
    LCR_PNL_ACTIVE  = 2'b01,
    LCR_PNL_REFL    = 2'b10,
    LCR_PNL_DIODE   = 2'b11
  } lcr_panel_t;

  typedef enum logic [1:0] {
    LCR_WID_4_9   = 2'b00,
    LCR_WID_8_12  = 2'b01,
    LCR_WID_16_18 = 2'b10,
    LCR_WID_RSVD  = 2'b11
  } lcr_width_t;

endpackage

// ---- rtl/lcr_div.sv ----
// enable-pulse clock divider with period-boundary reload
// assumes src_en is a one-cycle enable on core_clk
`timescale 1ns/1ps
module lcr_div #(
  parameter int CW = 3
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          src_en,
  input  wire logic [CW-1:0] div_n,
  output logic               tick_ff
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] cur_ff;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // reload at boundary
  // new ratio only taken when a period completes, so no runt period
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_ff  <= '0;
      cur_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (src_en) begin
        if (cnt_ff >= cur_ff) begin
          cnt_ff  <= '0;
          cur_ff  <= div_n;
          tick_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_div_bound: assert property (cnt_ff <= cur_ff)
    else $error("divider count beyond active ratio");
  a_div_reload: assert property (
    (src_en && cnt_ff == cur_ff) |=> (tick_ff && cur_ff == $past(div_n)))
    else $error("divider did not tick and reload at boundary");
  a_div_midhold: assert property (
    (src_en && cnt_ff < cur_ff) |=> (!tick_ff && $stable(cur_ff)))
    else $error("divider ratio changed mid period");

endmodule

// ---- rtl/lcr_regs.sv ----
// lcd controller register bank: identity, straps, clock dividers,
// colour lookup tables and panel kind; host bus is synchronous to core_clk
`timescale 1ns/1ps
module lcr_regs #(
  parameter logic [5:0] PRODUCT_CODE  = 6'h15,  // arbitrary value
  parameter logic [1:0] REVISION_CODE = 2'h1,   // arbitrary value
  parameter int         LUT_DEPTH     = 256,
  parameter int         LUT_W         = 6
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        mr_n,
  input  wire logic        we_n,
  input  wire logic        rd_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  input  wire logic [7:0]  configuration_straps,
  input  wire logic        primary_clock_input,
  input  wire logic        secondary_clock_input,
  output logic             mem_clk_en,
  output logic             pix_clk_en,
  output logic      [1:0]  panel_kind,
  output logic      [1:0]  panel_width,
  output logic             panel_mono,
  output logic             panel_format,
  output logic             active_res_sel
);

  logic             reg_sel, wr_en, rd_en, wr_wptr, wr_rptr;
  logic [7:0]       rdata_ff, nxt_rdata, rptr_ff, strap_s1_ff, strap_s2_ff, strap_ff;
  logic [1:0]       mclk_div_ff, pclk_src_ff, pix_src_ff, panel_wid_ff, panel_kind_ff;
  logic [2:0]       pclk_div_ff, pix_div_n, pri_sync_ff, sec_sync_ff;
  logic             pix_src_en, panel_fmt_ff, panel_mono_ff, panel_res_ff, res_eff_ff, rst_d_ff;
  logic [LUT_W-1:0] stg_ff [3];
  logic [LUT_W-1:0] rd_ff  [3];
  logic [LUT_W-1:0] lut_ff [3][LUT_DEPTH];

  function automatic logic hit(input logic [16:0] a, input logic [16:0] ofs);
    return a == ofs;
  endfunction

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // register space select
  assign reg_sel = !cs_n && !mr_n;
  assign wr_en   = reg_sel && !we_n;
  assign rd_en   = reg_sel && !rd_n;
  assign wr_wptr = wr_en && hit(addr, lcr_pkg::OFS_WPTR);
  assign wr_rptr = wr_en && hit(addr, lcr_pkg::OFS_RPTR);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // fixed identity, unused bits zero
  always_comb begin
    case (addr)
      lcr_pkg::OFS_ID:      nxt_rdata = {PRODUCT_CODE, REVISION_CODE};
      lcr_pkg::OFS_BUFSZ:   nxt_rdata = lcr_pkg::BUF_SIZE_VAL;
      lcr_pkg::OFS_STRAP:   nxt_rdata = strap_ff;
      lcr_pkg::OFS_MCLK:    nxt_rdata = {2'h0, mclk_div_ff, 4'h0};
      lcr_pkg::OFS_PCLK:    nxt_rdata = {1'b0, pclk_div_ff, 2'h0, pclk_src_ff};
      lcr_pkg::OFS_WDATA_B: nxt_rdata = {stg_ff[0], 2'h0};
      lcr_pkg::OFS_WDATA_G: nxt_rdata = {stg_ff[1], 2'h0};
      lcr_pkg::OFS_WDATA_R: nxt_rdata = {stg_ff[2], 2'h0};
      lcr_pkg::OFS_RDATA_B: nxt_rdata = {rd_ff[0], 2'h0};
      lcr_pkg::OFS_RDATA_G: nxt_rdata = {rd_ff[1], 2'h0};
      lcr_pkg::OFS_RDATA_R: nxt_rdata = {rd_ff[2], 2'h0};
      lcr_pkg::OFS_PANEL:   nxt_rdata = {panel_fmt_ff, panel_mono_ff, panel_wid_ff,
                                         panel_res_ff, 1'b0, panel_kind_ff};
      default:              nxt_rdata = lcr_pkg::RST_VAL;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_ff <= lcr_pkg::RST_VAL;
    end else if (rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // clock and panel configuration
  // ---------------------------------------------------------------
  // zero at reset
  // bit 0 of the memory clock register is not stored, software keeps it 0
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mclk_div_ff <= '0;
      pclk_div_ff <= '0;
      pclk_src_ff <= '0;
    end else begin
      if (wr_en && hit(addr, lcr_pkg::OFS_MCLK)) begin
        mclk_div_ff <= wdata[lcr_pkg::MCLK_DIV_LSB +: 2];
      end
      if (wr_en && hit(addr, lcr_pkg::OFS_PCLK)) begin
        pclk_div_ff <= wdata[lcr_pkg::PCLK_DIV_LSB +: 3];
        pclk_src_ff <= wdata[lcr_pkg::PCLK_SRC_LSB +: 2];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      panel_fmt_ff  <= 1'b0;
      panel_mono_ff <= 1'b0;
      panel_wid_ff  <= '0;
      panel_res_ff  <= 1'b0;
      panel_kind_ff <= '0;
    end else if (wr_en && hit(addr, lcr_pkg::OFS_PANEL)) begin
      panel_fmt_ff  <= wdata[lcr_pkg::PANEL_FMT_BIT];
      panel_mono_ff <= wdata[lcr_pkg::PANEL_MON_BIT];
      panel_wid_ff  <= wdata[lcr_pkg::PANEL_WID_LSB +: 2];
      panel_res_ff  <= wdata[lcr_pkg::PANEL_RES_BIT];
      panel_kind_ff <= wdata[lcr_pkg::PANEL_KND_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      res_eff_ff <= 1'b0;
    end else begin
      res_eff_ff <= panel_res_ff &&
                    (panel_kind_ff == lcr_pkg::LCR_PNL_REFL ||
                     panel_kind_ff == lcr_pkg::LCR_PNL_DIODE);
    end
  end

  // ---------------------------------------------------------------
  // straps
  // ---------------------------------------------------------------
  // sync chain is data only, so it keeps running through reset
  always_ff @(posedge core_clk) begin
    strap_s1_ff <= configuration_straps;
    strap_s2_ff <= strap_s1_ff;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rst_d_ff <= 1'b1;
      strap_ff <= lcr_pkg::RST_VAL;
    end else begin
      rst_d_ff <= 1'b0;
      if (rst_d_ff) begin
        strap_ff <= strap_s2_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // clock generation
  // ---------------------------------------------------------------
  // input clocks must be well under core_clk / 4 to be seen
  always_ff @(posedge core_clk) begin
    pri_sync_ff <= {pri_sync_ff[1:0], primary_clock_input};
    sec_sync_ff <= {sec_sync_ff[1:0], secondary_clock_input};
  end

  lcr_div #(.CW(3)) u_mem_div (
    .core_clk (core_clk),
    .rst      (rst),
    .src_en   (1'b1),
    .div_n    ({1'b0, mclk_div_ff}),
    .tick_ff  (mem_clk_en)
  );

  // source swap at boundary
  // a stopped old source holds the swap off until it ticks again
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pix_src_ff <= lcr_pkg::LCR_SRC_MEM;
    end else if (pix_clk_en) begin
      pix_src_ff <= pclk_src_ff;
    end
  end

  always_comb begin
    case (pix_src_ff)
      lcr_pkg::LCR_SRC_MEM: pix_src_en = mem_clk_en;
      lcr_pkg::LCR_SRC_BUS: pix_src_en = 1'b1;
      lcr_pkg::LCR_SRC_PRI: pix_src_en = pri_sync_ff[1] && !pri_sync_ff[2];
      default:              pix_src_en = sec_sync_ff[1] && !sec_sync_ff[2];
    endcase
  end

  assign pix_div_n = pclk_div_ff[2] ? lcr_pkg::PCLK_DIV8_CNT : {1'b0, pclk_div_ff[1:0]};

  lcr_div #(.CW(3)) u_pix_div (
    .core_clk (core_clk),
    .rst      (rst),
    .src_en   (pix_src_en),
    .div_n    (pix_div_n),
    .tick_ff  (pix_clk_en)
  );

  // ---------------------------------------------------------------
  // colour lookup tables
  // ---------------------------------------------------------------
  // index 0 blue, 1 green, 2 red, following the register order
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rptr_ff <= '0;
    end else if (wr_rptr || wr_wptr) begin
      rptr_ff <= wdata;
    end
  end

  for (genvar c = 0; c < 3; c++) begin : g_col
    always_ff @(posedge core_clk) begin
      if (rst) begin
        stg_ff[c] <= '0;
      end else if (wr_en && hit(addr, lcr_pkg::OFS_WDATA_B + 17'(c))) begin
        stg_ff[c] <= wdata[lcr_pkg::LUT_DATA_LSB +: LUT_W];
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        for (int i = 0; i < LUT_DEPTH; i++) begin
          lut_ff[c][i] <= '0;
        end
      end else if (wr_wptr) begin
        lut_ff[c][wdata] <= stg_ff[c];
      end
    end

    // refresh on pointer load
    // write pointer load reads the entry being written, hence the bypass
    always_ff @(posedge core_clk) begin
      if (rst) begin
        rd_ff[c] <= '0;
      end else if (wr_wptr) begin
        rd_ff[c] <= stg_ff[c];
      end else if (wr_rptr) begin
        rd_ff[c] <= lut_ff[c][wdata];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata          = rdata_ff;
  assign panel_kind     = panel_kind_ff;
  assign panel_width    = panel_wid_ff;
  assign panel_mono     = panel_mono_ff;
  assign panel_format   = panel_fmt_ff;
  assign active_res_sel = res_eff_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_id_readback: assert property (
    (rd_en && hit(addr, lcr_pkg::OFS_ID)) |=> rdata == {PRODUCT_CODE, REVISION_CODE})
    else $error("identity read wrong");
  a_ptr_read_zero: assert property (
    (rd_en && (hit(addr, lcr_pkg::OFS_WPTR) || hit(addr, lcr_pkg::OFS_RPTR)))
      |=> rdata == 8'h00)
    else $error("pointer register did not read zero");
  a_strap_capture: assert property (
    rst_d_ff |=> strap_ff == $past(strap_s2_ff) ##1 $stable(strap_ff)[*3])
    else $error("strap readback not latched at release");
  a_stage_load: assert property (
    (wr_en && hit(addr, lcr_pkg::OFS_WDATA_R))
      |=> stg_ff[2] == $past(wdata[7:2]))
    else $error("red staging not loaded");
  a_lut_commit: assert property (
    wr_wptr |=> lut_ff[0][$past(wdata)] == $past(stg_ff[0])
             && lut_ff[2][$past(wdata)] == $past(stg_ff[2]))
    else $error("table entry not committed");
  a_rptr_follow: assert property (
    wr_wptr |=> rptr_ff == $past(wdata))
    else $error("read pointer did not follow write pointer");
  a_rdata_refresh: assert property (
    (wr_rptr && !wr_wptr) |=> rd_ff[1] == $past(lut_ff[1][wdata]))
    else $error("read data not refreshed");
  a_rdata_hold: assert property (
    (!wr_rptr && !wr_wptr) |=> $stable(rd_ff[1]))
    else $error("read data changed without pointer load");
  a_res_gate: assert property (
    (panel_kind_ff == lcr_pkg::LCR_PNL_PASSIVE || panel_kind_ff == lcr_pkg::LCR_PNL_ACTIVE)
      |=> !active_res_sel)
    else $error("resolution select leaked to other panel");
  a_unused_zero: assert property (
    (rd_en && hit(addr, lcr_pkg::OFS_PANEL)) |=> rdata[2] == 1'b0)
    else $error("unused panel bit not zero");
  a_bus_pix_rate: assert property (
    (pix_src_ff == lcr_pkg::LCR_SRC_BUS && pix_div_n == 3'h1 && pix_clk_en
     && pclk_src_ff == lcr_pkg::LCR_SRC_BUS && $stable(pix_div_n))
      |=> !pix_clk_en ##1 pix_clk_en)
    else $error("bus sourced pixel clock not 2:1");

  c_lut_walk: cover property (wr_wptr ##[1:8] (rd_en && hit(addr, lcr_pkg::OFS_RDATA_R)));
  c_rptr_load: cover property (wr_rptr ##1 (rd_en && hit(addr, lcr_pkg::OFS_RDATA_B)));
  c_pix_div8: cover property (pclk_div_ff[2] && pix_clk_en);
  c_src_swap: cover property (pix_clk_en && pix_src_ff != pclk_src_ff);

endmodule

// ---- verif/lcr_host.sv ----
// host cpu model for the lcr_regs register bus
// assumes one core_clk domain; requests launch just after a rising edge
`timescale 1ns/1ps
module lcr_host (
  input  wire logic        core_clk,
  output logic             cs_n,
  output logic             mr_n,
  output logic             we_n,
  output logic             rd_n,
  output logic      [16:0] addr,
  output logic      [7:0]  wdata,
  input  wire logic [7:0]  rdata
);
  initial begin
    cs_n  = 1'h1;
    mr_n  = 1'h1;
    we_n  = 1'h1;
    rd_n  = 1'h1;
    addr  = 17'h0;
    wdata = 8'h0;
  end

  // ----------
  // one bus transfer, read data sampled a cycle after the taking edge
  // ----------
  task automatic xfer(input logic w, input logic m, input logic [16:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    cs_n  <= 1'h0;
    mr_n  <= m;
    we_n  <= ~w;
    rd_n  <= w;
    addr  <= a;
    wdata <= (a == lcr_pkg::OFS_MCLK) ? (d & 8'hfe) : d;
    @(posedge core_clk);
    cs_n  <= 1'h1;
    mr_n  <= 1'h1;
    we_n  <= 1'h1;
    rd_n  <= 1'h1;
    // released lines flip so stale values never look valid
    addr  <= ~a;
    wdata <= ~d;
    @(posedge core_clk);
    #1 q = rdata;
  endtask
endmodule

// ---- verif/tb_lcd_config_clock_lut_regs.sv ----
// self-checking bench for lcr_regs: map, lookup tables, clock enables,
// panel outputs and mid-run reset
// assumes lcr_host as bus master and a 20 MHz core_clk
`timescale 1ns/1ps
module tb_lcd_config_clock_lut_regs;
  typedef struct packed {
    logic        w;
    logic [16:0] a;
    logic [7:0]  d;
  } lcr_row_t;
  localparam logic W = 1'h1;
  localparam logic R = 1'h0;
  logic        core_clk, rst, cs_n, mr_n, we_n, rd_n, pri_clk, sec_clk;
  logic        mem_clk_en, pix_clk_en, panel_mono, panel_format, active_res_sel;
  logic [1:0]  panel_kind, panel_width;
  logic [7:0]  rdata, wdata, straps, q;
  logic [16:0] addr;
  int          errors, samples_checked, i, k;
  logic [7:0]  pdiv [9] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h71, 8'h10, 8'h02, 8'h13};
  logic [7:0]  pexp [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h18};
  lcr_row_t    rows [50] = '{
    '{R, 17'h0, 8'h55}, '{R, 17'h1, 8'h14}, '{R, 17'h2, 8'ha5}, '{R, 17'h4, 8'h00},
    '{R, 17'h5, 8'h00}, '{R, 17'h10, 8'h00}, '{W, 17'h0, 8'hff}, '{R, 17'h0, 8'h55},
    '{W, 17'h1, 8'h00}, '{R, 17'h1, 8'h14}, '{W, 17'h2, 8'h00}, '{R, 17'h2, 8'ha5},
    '{W, 17'h4, 8'hf0}, '{R, 17'h4, 8'h30}, '{W, 17'h5, 8'hff}, '{R, 17'h5, 8'h73},
    '{W, 17'h10, 8'hff}, '{R, 17'h10, 8'hfb}, '{W, 17'h3, 8'hff}, '{R, 17'h3, 8'h00},
    '{R, 17'h11, 8'h00}, '{R, 17'h10004, 8'h00}, '{R, 17'h4, 8'h30}, '{W, 17'h8, 8'hfc},
    '{W, 17'h9, 8'ha8}, '{W, 17'ha, 8'h54}, '{R, 17'ha, 8'h54}, '{W, 17'hb, 8'h05},
    '{R, 17'hb, 8'h00}, '{R, 17'hf, 8'h00}, '{R, 17'hc, 8'hfc}, '{R, 17'hd, 8'ha8},
    '{R, 17'he, 8'h54}, '{W, 17'h8, 8'h04}, '{W, 17'h9, 8'h08}, '{W, 17'ha, 8'h0c},
    '{W, 17'hb, 8'hff}, '{W, 17'h8, 8'h80}, '{R, 17'hc, 8'h04}, '{W, 17'hf, 8'h05},
    '{R, 17'hc, 8'hfc}, '{R, 17'hd, 8'ha8}, '{R, 17'he, 8'h54}, '{W, 17'hf, 8'hff},
    '{R, 17'hc, 8'h04}, '{R, 17'hd, 8'h08}, '{R, 17'he, 8'h0c}, '{W, 17'hf, 8'h00},
    '{R, 17'he, 8'h00}, '{R, 17'h0, 8'h55}};

  lcr_regs uut (
    .core_clk              (core_clk),
    .rst                   (rst),
    .cs_n                  (cs_n),
    .mr_n                  (mr_n),
    .we_n                  (we_n),
    .rd_n                  (rd_n),
    .addr                  (addr),
    .wdata                 (wdata),
    .rdata                 (rdata),
    .configuration_straps  (straps),
    .primary_clock_input   (pri_clk),
    .secondary_clock_input (sec_clk),
    .mem_clk_en            (mem_clk_en),
    .pix_clk_en            (pix_clk_en),
    .panel_kind            (panel_kind),
    .panel_width           (panel_width),
    .panel_mono            (panel_mono),
    .panel_format          (panel_format),
    .active_res_sel        (active_res_sel)
  );

  lcr_host host (
    .core_clk (core_clk),
    .cs_n     (cs_n),
    .mr_n     (mr_n),
    .we_n     (we_n),
    .rd_n     (rd_n),
    .addr     (addr),
    .wdata    (wdata),
    .rdata    (rdata)
  );

  // ----------
  // clocks; pin clocks kept well under a quarter of core_clk
  // ----------
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    pri_clk = 1'h0;
    #13;
    forever #200 pri_clk = ~pri_clk;
  end
  initial begin
    sec_clk = 1'h0;
    #13;
    forever #300 sec_clk = ~sec_clk;
  end

  // ----------
  // helpers
  // ----------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // third gap is measured so a pending divider switch has landed
  task automatic period(input logic pix, input logic [7:0] exp);
    int n, c;
    for (c = 0; c < 3; c++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        #1 n++;
      end while ((pix ? pix_clk_en : mem_clk_en) !== 1'h1 && n < 100);
      if (n >= 100) begin
        errors++;
        test_done();
      end
    end
    check(n[7:0], exp);
  endtask

  // ----------
  // main sequence
  // ----------
  initial begin
    rst             = 1'h1;
    straps          = 8'ha5;
    errors          = 0;
    samples_checked = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      host.xfer(rows[i].w, 1'h0, rows[i].a, rows[i].d, q);
      if (!rows[i].w) check(q, rows[i].d);
    end
    $display("register table done");
    for (k = 0; k < 4; k++) begin
      host.xfer(W, 1'h0, lcr_pkg::OFS_MCLK, 8'(k << 4), q);
      period(1'h0, 8'(k + 1));
    end
    for (k = 0; k < 9; k++) begin
      host.xfer(W, 1'h0, lcr_pkg::OFS_PCLK, pdiv[k], q);
      period(1'h1, pexp[k]);
    end
    $display("clock enables done");
    for (k = 0; k < 4; k++) begin
      host.xfer(W, 1'h0, lcr_pkg::OFS_PANEL, {k[1:0], 2'h2, 1'h1, 1'h0, k[1:0]}, q);
      check({6'h0, panel_kind}, 8'(k));
      check({6'h0, panel_width, panel_format, panel_mono}, 8'(8 + k));
      check({7'h0, active_res_sel}, {7'h0, k[1]});
    end
    $display("panel outputs done");
    // memory-space access must not reach the registers
    host.xfer(W, 1'h1, lcr_pkg::OFS_MCLK, 8'h00, q);
    host.xfer(R, 1'h0, lcr_pkg::OFS_MCLK, 8'h00, q);
    check(q, 8'h30);
    $display("space select done");
    @(posedge core_clk);
    straps <= 8'h3c;
    rst    <= 1'h1;
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    #1;
    check({panel_kind, panel_width, panel_mono, panel_format, active_res_sel, 1'h0}, 8'h00);
    check(rdata, 8'h00);
    host.xfer(R, 1'h0, lcr_pkg::OFS_STRAP, 8'h00, q);
    check(q, 8'h3c);
    host.xfer(R, 1'h0, lcr_pkg::OFS_PCLK, 8'h00, q);
    check(q, 8'h00);
    host.xfer(W, 1'h0, lcr_pkg::OFS_RPTR, 8'hff, q);
    host.xfer(R, 1'h0, lcr_pkg::OFS_RDATA_R, 8'h00, q);
    check(q, 8'h00);
    $display("mid-run reset done");
    test_done();
  end
endmodule
